// [bench/dac_bus_host_properties.sv]
// Purpose: Pin timing and order checks for the converter host
// Assumes: Pin timing of the host as built; all checks in the clock_i domain
// Notes:   Bound to every dac_bus_host by the statement at the foot
`timescale 1ns/1ps
`default_nettype none
`include "dac_host_defs.svh"
module dac_bus_host_properties (
    // Clock and reset
    input wire logic                    clock_i,
    input wire logic                    reset_i,
    // Request side
    input wire logic                    req_valid_i,
    input wire logic [11:0]             req_code_i,
    input wire dac_host_pkg::bus_mode_t req_mode_i,
    input wire logic                    twos_complement_coding_i,
    input wire logic                    req_ready_o,
    input wire logic                    write_done_o,
    input wire logic [11:0]             last_code_o,
    // Bus view
    input wire logic [1:0]              bus_addr_o,
    input wire logic [7:0]              bus_byte_o,
    // Converter pins
    input wire logic                    dac_cs_n_o,
    input wire logic                    low_nibble_select_n_o,
    input wire logic                    mid_nibble_select_n_o,
    input wire logic                    high_nibble_select_n_o,
    input wire logic                    output_rank_load_n_o,
    input wire logic [11:0]             dac_data_o
);
    import dac_host_pkg::*;

    // Selects gathered as {rank, high, mid, low}, and the taking edge
    wire logic [3:0] sel_n = {output_rank_load_n_o, high_nibble_select_n_o, mid_nibble_select_n_o,
                              low_nibble_select_n_o};
    wire logic       take  = req_valid_i && req_ready_o;

    ////////////////////////////////////////////////////////////////////////////
    // Strobe shape: selects and data must not move around the strobe edges
    a_cs_width: assert property (@(posedge clock_i) disable iff (reset_i)
        $fell(dac_cs_n_o) |=> !dac_cs_n_o ##1 dac_cs_n_o) else $error("chip select low width wrong");
    a_sel_setup: assert property (@(posedge clock_i) disable iff (reset_i)
        $fell(dac_cs_n_o) |-> $stable(sel_n) && $stable(dac_data_o) && sel_n != `SEL_NONE)
        else $error("selects or data moved at strobe start");
    a_sel_trail: assert property (@(posedge clock_i) disable iff (reset_i)
        $rose(dac_cs_n_o) && !$past(reset_i) |-> $stable(sel_n) && $stable(dac_data_o))
        else $error("selects moved at strobe end");
    a_ready_idle: assert property (@(posedge clock_i) disable iff (reset_i)
        req_ready_o |-> dac_cs_n_o && sel_n == `SEL_NONE) else $error("strobe while idle");
    a_done_pulse: assert property (@(posedge clock_i) disable iff (reset_i)
        write_done_o |-> req_ready_o ##1 !write_done_o) else $error("done not a single pulse");

    ////////////////////////////////////////////////////////////////////////////
    // Order and spacing of strobes per mode
    a_wide_data: assert property (@(posedge clock_i) disable iff (reset_i)
        take && req_mode_i == MODE_WIDE_OPEN |-> ##3 (!dac_cs_n_o && sel_n == `SEL_ALL
        && dac_data_o == ($past(req_code_i, 3) ^ {$past(twos_complement_coding_i, 3), 11'h000}))
        ##3 write_done_o) else $error("wide write wrong");
    a_left_order: assert property (@(posedge clock_i) disable iff (reset_i)
        take && req_mode_i == MODE_BYTE_LEFT |-> ##3 (sel_n == `SEL_LEFT_X01 && bus_addr_o == `ADDR_X01)
        ##5 (sel_n == `SEL_LEFT_X10 && bus_addr_o == `ADDR_X10) ##3 write_done_o) else $error("left order wrong");
    a_right_order: assert property (@(posedge clock_i) disable iff (reset_i)
        take && req_mode_i == MODE_BYTE_RIGHT |-> ##3 (sel_n == `SEL_RIGHT_X01 && bus_addr_o == `ADDR_X01)
        ##5 (sel_n == `SEL_RIGHT_X10 && bus_addr_o == `ADDR_X10) ##3 write_done_o) else $error("right order wrong");
    a_double_order: assert property (@(posedge clock_i) disable iff (reset_i)
        take && req_mode_i == MODE_WIDE_DOUBLE |-> ##3 (sel_n == `SEL_FIRST_RANK)
        ##5 (sel_n == `SEL_SECOND_RANK) ##3 write_done_o) else $error("double buffer order wrong");
endmodule

bind dac_bus_host dac_bus_host_properties chk (.clock_i, .reset_i, .req_valid_i, .req_code_i, .req_mode_i,
    .twos_complement_coding_i, .req_ready_o, .write_done_o, .last_code_o, .bus_addr_o, .bus_byte_o,
    .dac_cs_n_o, .low_nibble_select_n_o, .mid_nibble_select_n_o, .high_nibble_select_n_o,
    .output_rank_load_n_o, .dac_data_o);
`default_nettype wire

// [bench/dac_latch_model.sv]
// Purpose: Behavioural two-rank latched converter seen from its pins
// Assumes: Selects ordered {rank, high, mid, low}, all active low
// Notes:   No analog side; the output rank code stands for the output
`timescale 1ns/1ps
`default_nettype none
module dac_latch_model (
    // Control pins
    input  wire logic        cs_n_i,
    input  wire logic [3:0]  sel_n_i,
    // Data pins
    input  wire logic [11:0] data_i,
    // Code in the output rank
    output logic [11:0]      out_code_o
);
    logic [11:0] first_rank_reg;

    initial begin
        first_rank_reg = 12'h000;
        out_code_o = 12'h000;
    end

    // Level latches; first rank updates before the copy so an open pair passes straight through
    always @* begin
        if (!cs_n_i) begin
            if (!sel_n_i[0]) first_rank_reg[3:0] = data_i[3:0];
            if (!sel_n_i[1]) first_rank_reg[7:4] = data_i[7:4];
            if (!sel_n_i[2]) first_rank_reg[11:8] = data_i[11:8];
            if (!sel_n_i[3]) out_code_o = first_rank_reg;
        end
    end
endmodule
`default_nettype wire

// [bench/test_dac_bus_host.sv]
// Purpose: Self-checking bench for the converter host
// Assumes: Inputs driven at the falling edge; one request at a time
// Notes:   Byte writes are captured at the first low cycle of each strobe
`timescale 1ns/1ps
`default_nettype none
module test_dac_bus_host;
    import dac_host_pkg::*;

    logic        clock, reset, req_valid, twos_coding, cs_prev;
    logic [11:0] req_code;
    bus_mode_t   req_mode;
    wire logic   ready, done, cs_n, low_n, mid_n, high_n, rank_n;
    wire logic [11:0] last_code, data, model_out;
    wire logic [1:0]  bus_addr;
    wire logic [7:0]  bus_byte;
    logic [1:0]  cap_addr [2];
    logic [7:0]  cap_byte [2];
    logic [11:0] cap_out [2];
    int          n_strobe, n_mismatch, check_count, cycles;

    dac_bus_host dut (.clock_i(clock), .reset_i(reset), .req_valid_i(req_valid), .req_code_i(req_code),
        .req_mode_i(req_mode), .twos_complement_coding_i(twos_coding), .req_ready_o(ready),
        .write_done_o(done), .last_code_o(last_code), .bus_addr_o(bus_addr), .bus_byte_o(bus_byte),
        .dac_cs_n_o(cs_n), .low_nibble_select_n_o(low_n), .mid_nibble_select_n_o(mid_n),
        .high_nibble_select_n_o(high_n), .output_rank_load_n_o(rank_n), .dac_data_o(data));
    dac_latch_model model (.cs_n_i(cs_n), .sel_n_i({rank_n, high_n, mid_n, low_n}), .data_i(data),
        .out_code_o(model_out));

    ////////////////////////////////////////////////////////////////////////////
    // Clock, strobe capture and hang guard
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(negedge clock) begin
        if (cs_prev && !cs_n && n_strobe < 2) begin
            cap_addr[n_strobe] = bus_addr;
            cap_byte[n_strobe] = bus_byte;
            cap_out[n_strobe] = model_out;
            n_strobe++;
        end
        cs_prev = cs_n;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input logic [11:0] act, input logic [11:0] exp, input string what);
        check_count++;
        if (act !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, act, exp);
        end
    endtask

    // Called at a falling edge; a request set right after done is taken back to back
    task automatic send(input logic [11:0] code, input bus_mode_t mode, input logic tc, input int lat);
        int n;
        n = 0;
        n_strobe = 0;
        req_valid = 1'b1;
        req_code = code;
        req_mode = mode;
        twos_coding = tc;
        @(negedge clock);
        req_valid = 1'b0;
        while (done !== 1'b1 && n < 20) begin
            @(negedge clock);
            n++;
        end
        check(12'(n), 12'(lat - 1), "done latency");
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_wide();
        logic [11:0] codes [4] = '{12'h000, 12'hfff, 12'h800, 12'h5a3};
        foreach (codes[i]) begin
            send(codes[i], MODE_WIDE_OPEN, 1'b0, 6);
            check(model_out, codes[i], "wide output");
        end
    endtask

    task automatic test_twos();
        send(12'h7ff, MODE_WIDE_DOUBLE, 1'b1, 11);
        check(cap_out[0], 12'h5a3, "double output early");
        check(model_out, 12'hfff, "inverted top bit");
        check(last_code, 12'hfff, "last code");
    endtask

    task automatic test_left();
        send(12'h9c6, MODE_BYTE_LEFT, 1'b0, 11);
        check(12'(cap_addr[0]), 12'h001, "left first offset");
        check(12'(cap_byte[0]), 12'h060, "left low nibble byte");
        check(12'(cap_byte[1]), 12'h09c, "left upper byte");
        check(cap_out[0], 12'hfff, "left output early");
        check(model_out, 12'h9c6, "left output");
    endtask

    task automatic test_right();
        send(12'h3b5, MODE_BYTE_RIGHT, 1'b1, 11);
        check(12'(cap_byte[0]), 12'h0b5, "right low byte");
        check(12'(cap_byte[1]), 12'h00b, "right upper byte");
        check(cap_out[0], 12'h9c6, "right output early");
        check(model_out, 12'hbb5, "right output");
    endtask

    // Reset in the middle of a strobe must leave the pins idle
    task automatic test_reset();
        req_valid = 1'b1;
        req_code = 12'h123;
        req_mode = MODE_WIDE_OPEN;
        twos_coding = 1'b0;
        @(negedge clock);
        req_valid = 1'b0;
        repeat (2) @(negedge clock);
        reset = 1'b1;
        @(negedge clock);
        check(12'({cs_n, ready, done}), 12'h006, "pins after reset");
        check(last_code, 12'h000, "last code after reset");
        reset = 1'b0;
        send(12'h456, MODE_WIDE_OPEN, 1'b0, 6);
        check(model_out, 12'h456, "output after reset");
    endtask

    initial begin
        reset = 1'b1;
        req_valid = 1'b0;
        req_code = 12'h000;
        req_mode = MODE_WIDE_OPEN;
        twos_coding = 1'b0;
        cs_prev = 1'b1;
        repeat (6) @(negedge clock);
        reset = 1'b0;
        test_wide();
        test_twos();
        test_left();
        test_right();
        test_reset();
        stop_test();
    end
endmodule
`default_nettype wire

// [design/dac_bus_host.sv]
// Purpose: Host controller that writes 12-bit codes into a two-rank latched converter
// Assumes: Converter pins driven directly; byte modes mimic the 8-bit wiring on the pins
// Notes:   Mode and coding are sampled with each request, so they may change between codes
`timescale 1ns/1ps
`default_nettype none
`include "dac_host_defs.svh"
module dac_bus_host (
    // Clock and reset
    input  wire logic                   clock_i,
    input  wire logic                   reset_i,
    // Request side
    input  wire logic                   req_valid_i,
    input  wire logic [11:0]            req_code_i,
    input  wire dac_host_pkg::bus_mode_t req_mode_i,
    input  wire logic                   twos_complement_coding_i,
    output logic                        req_ready_o,
    output logic                        write_done_o,
    output logic [11:0]                 last_code_o,
    // Bus view of the write in progress
    output logic [1:0]                  bus_addr_o,
    output logic [7:0]                  bus_byte_o,
    // Converter pins
    output logic                        dac_cs_n_o,
    output logic                        low_nibble_select_n_o,
    output logic                        mid_nibble_select_n_o,
    output logic                        high_nibble_select_n_o,
    output logic                        output_rank_load_n_o,
    output logic [11:0]                 dac_data_o
);
    import dac_host_pkg::*;

    host_state_t   state_reg;
    host_state_t   state_next;
    bus_mode_t     mode_reg;
    logic [11:0]   code_reg;
    logic          step_reg;
    logic          done_reg;
    logic [11:0]   last_reg;
    logic [1:0]    addr_reg;
    logic [7:0]    byte_reg;
    logic [3:0]    pin_sel_n;

    latch_write_if wr ();

    ////////////////////////////////////////////////////////////////////////
    // Coding: two's complement becomes offset binary by flipping the top bit
    logic [11:0] coded_code;
    logic        code_top_bit;
    assign code_top_bit = req_code_i[11] ^ twos_complement_coding_i; // RULE4
    assign coded_code   = {code_top_bit, req_code_i[10:0]}; // RULE3

    ////////////////////////////////////////////////////////////////////////
    // Byte formats for the two bus locations
    logic [7:0] left_x01_byte;
    logic [7:0] left_x10_byte;
    logic [7:0] right_x01_byte;
    logic [7:0] right_x10_byte;
    assign left_x01_byte  = {code_reg[3:0], 4'h0}; // RULE6
    assign left_x10_byte  = code_reg[11:4]; // RULE6
    assign right_x01_byte = code_reg[7:0]; // RULE7
    assign right_x10_byte = {4'h0, code_reg[11:8]}; // RULE7

    // Byte for the current step; wide modes show the low byte only
    logic       is_left;
    logic       is_right;
    logic       is_wide_open;
    logic [7:0] step_byte;
    assign is_left      = (mode_reg == MODE_BYTE_LEFT);
    assign is_right     = (mode_reg == MODE_BYTE_RIGHT);
    assign is_wide_open = (mode_reg == MODE_WIDE_OPEN);
    assign step_byte    = is_left  ? (step_reg ? left_x10_byte  : left_x01_byte)  :
                          is_right ? (step_reg ? right_x10_byte : right_x01_byte) :
                          code_reg[7:0];

    // Location: X01 then X10, for the bus view only; the selects come from the mode tables
    logic [1:0] step_addr;
    assign step_addr = (is_left || is_right) ? (step_reg ? `ADDR_X10 : `ADDR_X01) // RULE8
                                             : `ADDR_WIDE;

    ////////////////////////////////////////////////////////////////////////
    // Pin data as the 8-bit bus lands on the 12 inputs
    // Left wiring: bus D7..D0 to the top eight, bus D7..D4 also to the low four
    // Right wiring: bus D7..D0 to the low eight, bus D3..D0 also to the top four
    logic [11:0] step_data;
    assign step_data = is_left  ? {step_byte, step_byte[7:4]} : // RULE9
                       is_right ? {step_byte[3:0], step_byte} : // RULE10
                       code_reg; // RULE11

    // Selects for each mode and step, order {rank, high, mid, low}
    logic [3:0] left_sel_n;
    logic [3:0] right_sel_n;
    logic [3:0] double_sel_n;
    logic [3:0] step_sel_n;
    assign left_sel_n   = step_reg ? `SEL_LEFT_X10 : `SEL_LEFT_X01; // RULE9
    assign right_sel_n  = step_reg ? `SEL_RIGHT_X10 : `SEL_RIGHT_X01; // RULE10
    // Word first into the nibbles, then a separate copy, so a moving bus never shows
    assign double_sel_n = step_reg ? `SEL_SECOND_RANK : `SEL_FIRST_RANK; // RULE13
    assign step_sel_n   = is_left      ? left_sel_n  :
                          is_right     ? right_sel_n :
                          is_wide_open ? `SEL_ALL    : // RULE11
                          double_sel_n;

    // A single pulse for the open word, two writes otherwise
    logic last_step;
    assign last_step = is_wide_open || step_reg; // RULE5

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state machine
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:  if (req_valid_i) state_next = ST_ISSUE;
            ST_ISSUE: state_next = ST_WAIT;
            ST_WAIT: begin
                if (wr.done) begin
                    state_next = last_step ? ST_IDLE : ST_ISSUE;
                end
            end
            default:  state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Request capture; the open word relies on both ranks following the pins
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            mode_reg <= MODE_WIDE_OPEN;
            code_reg <= 12'h000;
        end else if (state_reg == ST_IDLE && req_valid_i) begin
            mode_reg <= req_mode_i; // RULE16
            code_reg <= coded_code; // RULE2
        end
    end

    // Step index: first write, then second
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            step_reg <= 1'b0;
        end else if (state_reg == ST_IDLE) begin
            step_reg <= 1'b0;
        end else if (state_reg == ST_WAIT && wr.done) begin
            step_reg <= 1'b1; // RULE5
        end
    end

    // Completion pulse and the code last written
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            done_reg <= 1'b0;
            last_reg <= 12'h000;
        end else begin
            done_reg <= (state_reg == ST_WAIT) && wr.done && last_step;
            if (state_reg == ST_WAIT && wr.done && last_step) begin
                last_reg <= code_reg;
            end
        end
    end

    // Bus view, updated as each write is issued
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            addr_reg <= `ADDR_WIDE;
            byte_reg <= 8'h00;
        end else if (state_reg == ST_ISSUE) begin
            addr_reg <= step_addr;
            byte_reg <= step_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobe generator; a change of data under an open word is avoided by holding it
    assign wr.start = (state_reg == ST_ISSUE);
    assign wr.sel_n = step_sel_n;
    assign wr.data  = step_data; // RULE12

    latch_strobe u_strobe (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .wr      (wr.strobe),
        .cs_n_o  (dac_cs_n_o),
        .sel_n_o (pin_sel_n),
        .data_o  (dac_data_o)
    );

    assign low_nibble_select_n_o  = pin_sel_n[0];
    assign mid_nibble_select_n_o  = pin_sel_n[1];
    assign high_nibble_select_n_o = pin_sel_n[2];
    assign output_rank_load_n_o   = pin_sel_n[3];

    // Outputs
    assign req_ready_o  = (state_reg == ST_IDLE);
    assign write_done_o = done_reg;
    assign last_code_o  = last_reg;
    assign bus_addr_o   = addr_reg;
    assign bus_byte_o   = byte_reg;
endmodule
`default_nettype wire

// [design/dac_host_defs.svh]
// Purpose: Constants for the host that loads a 12-bit latched converter over its pins
// Assumes: Clock of 50 ns period; selects are ordered {rank, high, mid, low}
// Notes:   Behaviour list of the converter and of this host follows
// Behaviour
// [RULE1] The converter reads its 12 data pins as positive-true binary, high meaning a one.
// [RULE2] Unipolar wiring uses straight binary, 000 gives zero and FFF one step below full scale.
// [RULE3] Bipolar wiring uses offset binary, 000 gives minus full scale, 800 zero, FFF one step below plus.
// [RULE4] A host holding two's complement values inverts only the top code bit before it reaches the pins.
// [RULE5] On an 8-bit bus every 12-bit code is sent as two separate byte writes.
// [RULE6] Left-justified, one byte carries the eight upper bits and the next the four low bits in its upper nibble.
// [RULE7] Right-justified, one byte carries the eight low bits and the next the four upper bits in its lower nibble.
// [RULE8] Chip select comes from a high address decode and the two lowest address bits drive the latch selects. The host drives both directly.
// [RULE9] Left-justified, offset X01 loads the four low bits and X10 loads the eight upper bits and updates.
// [RULE10] Right-justified, offset X01 loads the eight low bits and X10 loads the four upper bits and updates.
// [RULE11] On a 12- or 16-bit bus all four selects are held low so chip select alone opens every latch.
// [RULE12] With both ranks open, any data change while chip select is low reaches the output.
// [RULE13] A host whose data may move during chip select low uses the second rank separately.
// [RULE14] Every latch is transparent while its select is low and holds once it returns high.
// [RULE15] Under chip select low each select opens its nibble or copies the first rank into the second.
// [RULE16] Several latches may open at once and a first-rank latch passes straight into an open second rank.
`ifndef DAC_HOST_DEFS_SVH
`define DAC_HOST_DEFS_SVH

// Bus timing in ns, and the clock period
`define CLK_PERIOD_NS   50
`define T_CS_WIDTH_NS   100
`define T_ADDR_SETUP_NS 100
`define T_DATA_SETUP_NS 50
// Least chip select low time, rounded up; it also covers both setups
`define CS_LOW_CYCLES   ((`T_CS_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Select patterns, active low, order {rank, high, mid, low}
`define SEL_NONE        4'hf
`define SEL_ALL         4'h0
`define SEL_LEFT_X01    4'he
`define SEL_LEFT_X10    4'h1
`define SEL_RIGHT_X01   4'hc
`define SEL_RIGHT_X10   4'h3
`define SEL_FIRST_RANK  4'h8
`define SEL_SECOND_RANK 4'h7

// Bus offsets of the two byte locations
`define ADDR_WIDE       2'h0
`define ADDR_X01        2'h1
`define ADDR_X10        2'h2

`endif

// [design/dac_host_pkg.sv]
// Purpose: Types shared by the converter host modules
// Assumes: Nothing beyond the defines header
// Notes:   Binary state codes written out
package dac_host_pkg;
    typedef enum logic [1:0] {
        MODE_WIDE_OPEN   = 2'h0,
        MODE_WIDE_DOUBLE = 2'h1,
        MODE_BYTE_LEFT   = 2'h2,
        MODE_BYTE_RIGHT  = 2'h3
    } bus_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_ISSUE = 2'h1,
        ST_WAIT  = 2'h2
    } host_state_t;

    typedef enum logic [1:0] {
        SS_IDLE  = 2'h0,
        SS_SETUP = 2'h1,
        SS_LOW   = 2'h2,
        SS_HOLD  = 2'h3
    } strobe_state_t;
endpackage

// [design/latch_strobe.sv]
// Purpose: Drives one chip select pulse with selects and data around it
// Assumes: start only while idle
// Notes:   Selects and data lead the strobe by one cycle; selects trail it by one, data holds until the next write
`timescale 1ns/1ps
`default_nettype none
`include "dac_host_defs.svh"
module latch_strobe #(
    parameter int CNT_W = 4
) (
    // Clock and reset
    input  wire logic          clock_i,
    input  wire logic          reset_i,
    // Request from the sequencer
    latch_write_if.strobe      wr,
    // Converter pins
    output logic               cs_n_o,
    output logic [3:0]         sel_n_o,
    output logic [11:0]        data_o
);
    import dac_host_pkg::*;

    strobe_state_t     state_reg;
    strobe_state_t     state_next;
    logic [CNT_W-1:0]  count_reg;
    logic              cs_n_reg;
    logic [3:0]        sel_n_reg;
    logic [11:0]       data_reg;

    ////////////////////////////////////////////////////////////////////////
    // Sequence: setup, strobe low, trailing hold
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SS_IDLE:  if (wr.start) state_next = SS_SETUP;
            SS_SETUP: state_next = SS_LOW;
            SS_LOW:   if (count_reg == '0) state_next = SS_HOLD;
            SS_HOLD:  state_next = SS_IDLE;
            default:  state_next = SS_IDLE;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_reg <= SS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Strobe width counter; low time is never cut short
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            count_reg <= '0;
        end else if (state_reg == SS_SETUP) begin
            count_reg <= CNT_W'(`CS_LOW_CYCLES - 1);
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    // Chip select low only in the strobe phase, so address and data are set up ahead
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            cs_n_reg <= 1'b1;
        end else begin
            cs_n_reg <= (state_next != SS_LOW); // RULE14
        end
    end

    // Selects held through the trailing cycle so no latch sees them rise first
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sel_n_reg <= `SEL_NONE;
        end else if (state_reg == SS_IDLE && wr.start) begin
            sel_n_reg <= wr.sel_n; // RULE15
        end else if (state_reg == SS_HOLD) begin
            sel_n_reg <= `SEL_NONE;
        end
    end

    // Data stays put until the next write, giving hold margin for free
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            data_reg <= 12'h000;
        end else if (state_reg == SS_IDLE && wr.start) begin
            data_reg <= wr.data; // RULE1
        end
    end

    assign wr.done = (state_reg == SS_HOLD);
    assign cs_n_o  = cs_n_reg;
    assign sel_n_o = sel_n_reg;
    assign data_o  = data_reg;
endmodule
`default_nettype wire

// [design/latch_write_if.sv]
// Purpose: Carries one latch write from the sequencer to the strobe generator
// Assumes: Same clock on both sides
// Notes:   start is a one-cycle pulse, done is high for one cycle
`timescale 1ns/1ps
`default_nettype none
interface latch_write_if;
    logic        start;
    logic [3:0]  sel_n;
    logic [11:0] data;
    logic        done;
    modport seq    (output start, output sel_n, output data, input done);
    modport strobe (input start, input sel_n, input data, output done);
endinterface
`default_nettype wire
